// File: hdl/eit_pkg.sv
// Constants, register map and state layout of the trigger-select block
package eit_pkg;

   // ------------------------------------------------------------
   // Register indices (word index; byte address is four times it)
   // ------------------------------------------------------------
   localparam logic [31:0] IDX_G2_FALL = 32'hFFFFFC04;
   localparam logic [31:0] IDX_G5_FALL = 32'hFFFFFC0A;
   localparam logic [31:0] IDX_G6_FALL = 32'hFFFFFC0C;
   localparam logic [31:0] IDX_GL_FALL = 32'hFFFFFC10;
   localparam logic [31:0] IDX_G2_RISE = 32'hFFFFFC24;
   localparam logic [31:0] IDX_G5_RISE = 32'hFFFFFC2A;
   localparam logic [31:0] IDX_G6_RISE = 32'hFFFFFC2C;
   localparam logic [31:0] IDX_GL_RISE = 32'hFFFFFC30;
   localparam logic [31:0] IDX_FLAG_STATUS = 32'hFFFFFC40;
   localparam logic [31:0] IDX_FLAG_CLEAR = 32'hFFFFFC44;
   localparam logic [31:0] IDX_FLAG_ENABLE = 32'hFFFFFC48;

   // ------------------------------------------------------------
   // Source layout: one byte lane per group, bit index = pin number
   // ------------------------------------------------------------
   localparam int G2_LSB = 0;
   localparam int G5_LSB = 8;
   localparam int G6_LSB = 16;
   localparam int GL_LSB = 24;
   localparam int NMI_BIT = 0;

   localparam logic [7:0] G2_MASK = 8'h3F;
   localparam logic [7:0] G5_MASK = 8'h07;
   localparam logic [7:0] G6_MASK = 8'hE0;
   localparam logic [7:0] GL_MASK = 8'h03;
   localparam logic [31:0] VALID_MASK = {GL_MASK, G6_MASK, G5_MASK, G2_MASK};
   localparam logic [31:0] NMI_MASK = 32'h00000001;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] G2_RISE_RST = 8'h3F;
   localparam logic [7:0] G5_RISE_RST = 8'h07;
   localparam logic [7:0] G6_RISE_RST = 8'hE0;
   localparam logic [7:0] GL_RISE_RST = 8'h03;
   localparam logic [31:0] RISE_RST =
      {GL_RISE_RST, G6_RISE_RST, G5_RISE_RST, G2_RISE_RST};
   localparam logic [31:0] FALL_RST = 32'h00000000;
   localparam logic [31:0] ENABLE_RST = 32'h00000000;

   // ------------------------------------------------------------
   // Timing: level sampling at main clock / 4, input filter warm-up
   // ------------------------------------------------------------
   localparam int LEVEL_DIV = 4;
   localparam logic [1:0] DIV_LAST = 2'(LEVEL_DIV - 1);
   localparam logic [1:0] WARM_DONE = 2'h3;

   // Trigger mode per pin, coded {falling bit, rising bit}
   typedef enum logic [1:0] {
      MODE_FALL  = 2'b00,
      MODE_RISE  = 2'b01,
      MODE_LEVEL = 2'b10,
      MODE_BOTH  = 2'b11
   } eit_mode_e;

   // Whole state of the block
   typedef struct packed {
      logic [31:0] fall;
      logic [31:0] rise;
      logic [31:0] enable;
      logic [31:0] flag;
      logic [31:0] sync1;
      logic [31:0] sync2;
      logic [31:0] sync3;
      logic [31:0] filt;
      logic [31:0] rdata;
      logic [1:0] div;
      logic [1:0] warm;
      logic bus_ack;
   } eit_state_s;

endpackage

// File: hdl/eit_trigger_select.sv
// Trigger-mode selection and request flags for external interrupt pins
//
// Notes on behaviour
// RQ1 - Falling/rising bit pair: 00 fall, 01 rise, 10 low level, 11 both.
// RQ2 - Group-2 pins 1..5 sit at bits 5..1 of group-2 registers.
// RQ3 - Group-5 pins 0..2 sit at bits 2..0 of group-5 registers.
// RQ4 - Group-6 pins 5..7 sit at bits 7..5 of group-6 registers.
// RQ5 - Fourth-group pins 0 and 1 sit at bits 0 and 1.
// RQ6 - Bit 0 of the group-2 registers selects the NMI trigger.
// RQ7 - Each pin's edge is chosen by its own bit pair alone.
// RQ8 - Low-level mode samples the pin every fourth main clock.
// RQ9 - A low sample in level mode latches the pin's request flag.
// RQ10 - Acknowledge clears the flag; a still-low pin sets it again.
// RQ11 - Service routine should release the pin, then clear the flag.
// RQ12 - A level request that goes away stays pending.
// RQ13 - Software clears the flag to drop such a pending request.
// RQ14 - Specification registers read and write as bytes or bits.
// RQ15 - Software sets pin mode before programming trigger bits.
// RQ16 - Unimplemented specification bits read zero, ignore writes.
`timescale 1ns/1ns
module eit_trigger_select (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   // Avalon-MM slave
   input wire logic [31:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Request pins
   input wire logic nmi_pin_i,
   input wire logic [5:1] group2_request_pin_i,
   input wire logic [2:0] group5_request_pin_i,
   input wire logic [7:5] group6_request_pin_i,
   input wire logic [1:0] group_l_request_pin_i,
   // Acknowledge from the CPU, one bit per source in flag layout
   input wire logic [31:0] irq_ack_i,
   // Interrupt outputs
   output logic irq_o,
   output logic nmi_o
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   eit_pkg::eit_state_s st_ff;
   eit_pkg::eit_state_s nxt_st;

   logic [31:0] pin_vec;
   logic [31:0] rise_ev;
   logic [31:0] fall_ev;
   logic [31:0] edge_set;
   logic [31:0] level_set;
   logic [31:0] flag_set;
   logic [31:0] flag_clr;
   logic [31:0] byte_mask;
   logic [31:0] lvl_low;
   logic [31:0] filt_nx;
   logic tick;
   logic armed;
   logic bus_req;
   logic wr_go;
   logic rd_go;

   // ------------------------------------------------------------
   // Pin gathering
   // ------------------------------------------------------------
   always_comb begin
      pin_vec = '0;
      pin_vec[eit_pkg::NMI_BIT] = nmi_pin_i; // [RQ6]
      pin_vec[eit_pkg::G2_LSB + 1 +: 5] = group2_request_pin_i; // [RQ2]
      pin_vec[eit_pkg::G5_LSB +: 3] = group5_request_pin_i; // [RQ3]
      pin_vec[eit_pkg::G6_LSB + 5 +: 3] = group6_request_pin_i; // [RQ4]
      pin_vec[eit_pkg::GL_LSB +: 2] = group_l_request_pin_i; // [RQ5]
   end

   // ------------------------------------------------------------
   // Bus handshake
   // ------------------------------------------------------------
   assign bus_req = avs_read_i | avs_write_i;
   assign avs_waitrequest_o = bus_req & ~st_ff.bus_ack;
   assign wr_go = avs_write_i & st_ff.bus_ack;
   assign rd_go = avs_read_i & ~st_ff.bus_ack;
   assign avs_readdata_o = st_ff.rdata;
   assign byte_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                       {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};

   // ------------------------------------------------------------
   // Detection
   // ------------------------------------------------------------
   assign tick = (st_ff.div == eit_pkg::DIV_LAST); // [RQ8]
   assign armed = (st_ff.warm == eit_pkg::WARM_DONE);
   assign lvl_low = st_ff.fall & ~st_ff.rise & ~st_ff.filt &
                    eit_pkg::VALID_MASK;

   always_comb begin
      // Filter: a change counts once the second and third stages agree;
      // in warm-up it tracks the second stage, so idle is not an edge
      if (armed) begin
         filt_nx = (st_ff.sync2 & st_ff.sync3) |
                   ((st_ff.sync2 ^ st_ff.sync3) & st_ff.filt);
      end else begin
         filt_nx = st_ff.sync2;
      end
      rise_ev = filt_nx & ~st_ff.filt & {32{armed}};
      fall_ev = ~filt_nx & st_ff.filt & {32{armed}};
      // Each pin decodes its own bit pair
      edge_set = (~st_ff.fall & ~st_ff.rise & fall_ev) | // [RQ1] [RQ7]
                 (~st_ff.fall & st_ff.rise & rise_ev) | // [RQ1] [RQ7]
                 (st_ff.fall & st_ff.rise & (rise_ev | fall_ev)); // [RQ1]
      level_set = lvl_low & {32{tick & armed}}; // [RQ8] [RQ9]
      flag_set = (edge_set | level_set) & eit_pkg::VALID_MASK;
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_st.fall = st_ff.fall;
      nxt_st.rise = st_ff.rise;
      nxt_st.enable = st_ff.enable;
      nxt_st.sync1 = pin_vec;
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.sync3 = st_ff.sync2;
      nxt_st.filt = filt_nx;
      nxt_st.rdata = st_ff.rdata;
      nxt_st.div = st_ff.div + 2'h1;
      nxt_st.warm = armed ? st_ff.warm : st_ff.warm + 2'h1;
      nxt_st.bus_ack = bus_req & ~st_ff.bus_ack;
      flag_clr = irq_ack_i; // [RQ10]

      // Register writes take effect on the cycle waitrequest is low
      if (wr_go) begin
         if (avs_address_i == eit_pkg::IDX_G2_FALL) begin
            if (avs_byteenable_i[0]) begin
               nxt_st.fall[eit_pkg::G2_LSB +: 8] =
                  avs_writedata_i[7:0] & eit_pkg::G2_MASK; // [RQ2] [RQ6]
            end
         end else if (avs_address_i == eit_pkg::IDX_G5_FALL) begin
            if (avs_byteenable_i[0]) begin
               nxt_st.fall[eit_pkg::G5_LSB +: 8] =
                  avs_writedata_i[7:0] & eit_pkg::G5_MASK; // [RQ3] [RQ16]
            end
         end else if (avs_address_i == eit_pkg::IDX_G6_FALL) begin
            if (avs_byteenable_i[0]) begin
               nxt_st.fall[eit_pkg::G6_LSB +: 8] =
                  avs_writedata_i[7:0] & eit_pkg::G6_MASK; // [RQ4] [RQ16]
            end
         end else if (avs_address_i == eit_pkg::IDX_GL_FALL) begin
            if (avs_byteenable_i[0]) begin
               nxt_st.fall[eit_pkg::GL_LSB +: 8] =
                  avs_writedata_i[7:0] & eit_pkg::GL_MASK; // [RQ5] [RQ16]
            end
         end else if (avs_address_i == eit_pkg::IDX_G2_RISE) begin
            if (avs_byteenable_i[0]) begin
               nxt_st.rise[eit_pkg::G2_LSB +: 8] =
                  avs_writedata_i[7:0] & eit_pkg::G2_MASK; // [RQ2] [RQ6]
            end
         end else if (avs_address_i == eit_pkg::IDX_G5_RISE) begin
            if (avs_byteenable_i[0]) begin
               nxt_st.rise[eit_pkg::G5_LSB +: 8] =
                  avs_writedata_i[7:0] & eit_pkg::G5_MASK; // [RQ3] [RQ14]
            end
         end else if (avs_address_i == eit_pkg::IDX_G6_RISE) begin
            if (avs_byteenable_i[0]) begin
               nxt_st.rise[eit_pkg::G6_LSB +: 8] =
                  avs_writedata_i[7:0] & eit_pkg::G6_MASK; // [RQ4] [RQ14]
            end
         end else if (avs_address_i == eit_pkg::IDX_GL_RISE) begin
            if (avs_byteenable_i[0]) begin
               nxt_st.rise[eit_pkg::GL_LSB +: 8] =
                  avs_writedata_i[7:0] & eit_pkg::GL_MASK; // [RQ5] [RQ14]
            end
         end else if (avs_address_i == eit_pkg::IDX_FLAG_CLEAR) begin
            flag_clr = flag_clr |
               (avs_writedata_i & byte_mask & eit_pkg::VALID_MASK);
         end else if (avs_address_i == eit_pkg::IDX_FLAG_ENABLE) begin
            nxt_st.enable = ((st_ff.enable & ~byte_mask) |
               (avs_writedata_i & byte_mask)) & eit_pkg::VALID_MASK;
         end
      end

      // A set in the same cycle as a clear wins
      nxt_st.flag = (st_ff.flag & ~flag_clr) | flag_set; // [RQ10] [RQ12]

      // Read data is captured in the first cycle of a read
      if (rd_go) begin
         if (avs_address_i == eit_pkg::IDX_G2_FALL) begin
            nxt_st.rdata = {24'h0, st_ff.fall[eit_pkg::G2_LSB +: 8]};
         end else if (avs_address_i == eit_pkg::IDX_G5_FALL) begin
            nxt_st.rdata = {24'h0, st_ff.fall[eit_pkg::G5_LSB +: 8]};
         end else if (avs_address_i == eit_pkg::IDX_G6_FALL) begin
            nxt_st.rdata = {24'h0, st_ff.fall[eit_pkg::G6_LSB +: 8]};
         end else if (avs_address_i == eit_pkg::IDX_GL_FALL) begin
            nxt_st.rdata = {24'h0, st_ff.fall[eit_pkg::GL_LSB +: 8]};
         end else if (avs_address_i == eit_pkg::IDX_G2_RISE) begin
            nxt_st.rdata = {24'h0, st_ff.rise[eit_pkg::G2_LSB +: 8]};
         end else if (avs_address_i == eit_pkg::IDX_G5_RISE) begin
            nxt_st.rdata = {24'h0, st_ff.rise[eit_pkg::G5_LSB +: 8]};
         end else if (avs_address_i == eit_pkg::IDX_G6_RISE) begin
            nxt_st.rdata = {24'h0, st_ff.rise[eit_pkg::G6_LSB +: 8]};
         end else if (avs_address_i == eit_pkg::IDX_GL_RISE) begin
            nxt_st.rdata = {24'h0, st_ff.rise[eit_pkg::GL_LSB +: 8]};
         end else if (avs_address_i == eit_pkg::IDX_FLAG_STATUS) begin
            nxt_st.rdata = st_ff.flag;
         end else if (avs_address_i == eit_pkg::IDX_FLAG_ENABLE) begin
            nxt_st.rdata = st_ff.enable;
         end else begin
            nxt_st.rdata = 32'h00000000;
         end
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_ff <= '0;
         st_ff.rise <= eit_pkg::RISE_RST;
         st_ff.fall <= eit_pkg::FALL_RST;
         st_ff.enable <= eit_pkg::ENABLE_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ------------------------------------------------------------
   // Interrupt outputs
   // ------------------------------------------------------------
   assign irq_o = |(st_ff.flag & st_ff.enable & ~eit_pkg::NMI_MASK);
   assign nmi_o = st_ff.flag[eit_pkg::NMI_BIT]; // [RQ6]

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking dflt_cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!reset_n_i);

   // Per-pin mode decode seen by the checks below
   logic [31:0] lvl_mode;
   logic [31:0] fall_hit;
   logic [31:0] both_hit;
   assign lvl_mode = st_ff.fall & ~st_ff.rise & eit_pkg::VALID_MASK;
   assign fall_hit = fall_ev & ~st_ff.fall & ~st_ff.rise &
                     eit_pkg::VALID_MASK;
   assign both_hit = (rise_ev | fall_ev) & st_ff.fall & st_ff.rise &
                     eit_pkg::VALID_MASK;

   level_sample_a: assert property ( // [RQ9]
      (tick && armed && lvl_low != 32'h0) |=>
         ((st_ff.flag & $past(lvl_low)) == $past(lvl_low)))
      else $error("low level sample did not latch the request flag");

   sample_period_a: assert property ( // [RQ8]
      tick |=> (!tick) [*3] ##1 tick)
      else $error("level sample tick is not every fourth clock");

   rise_mode_a: assert property ( // [RQ1]
      ((rise_ev & ~st_ff.fall & st_ff.rise & eit_pkg::VALID_MASK) != 0)
         |=> ((st_ff.flag & $past(rise_ev & st_ff.rise)) != 0))
      else $error("rising edge in rising mode set no flag");

   edge_independent_a: assert property ( // [RQ7]
      ((fall_ev & ~st_ff.fall & st_ff.rise & ~st_ff.flag) != 32'h0) |=>
         ((st_ff.flag & $past(fall_ev & ~st_ff.fall & st_ff.rise &
                              ~st_ff.flag)) == 32'h0))
      else $error("falling edge triggered a rising-only pin");

   reserved_zero_a: assert property ( // [RQ16]
      ((st_ff.fall | st_ff.rise | st_ff.flag | st_ff.enable) &
       ~eit_pkg::VALID_MASK) == 32'h0)
      else $error("unimplemented bit became set");

   ack_reset_a: assert property ( // [RQ10]
      ((irq_ack_i & flag_set) != 32'h0) |=>
         ((st_ff.flag & $past(irq_ack_i & flag_set)) != 32'h0))
      else $error("acknowledge lost a request set in the same cycle");

   pending_hold_a: assert property ( // [RQ12]
      (st_ff.flag != 32'h0 && irq_ack_i == 32'h0 && !avs_write_i) |=>
         ((st_ff.flag & $past(st_ff.flag)) == $past(st_ff.flag)))
      else $error("pending request dropped without a clear");

   bus_answer_a: assert property ( // [RQ14]
      bus_req |-> ##[0:1] !avs_waitrequest_o)
      else $error("bus request not answered within one cycle");

   group2_write_a: assert property ( // [RQ2]
      (wr_go && avs_byteenable_i[0] &&
       avs_address_i == eit_pkg::IDX_G2_RISE) |=>
         (st_ff.rise[7:0] == ($past(avs_writedata_i[7:0]) & 8'h3F)))
      else $error("group-2 rising register not written");

   nmi_route_a: assert property ( // [RQ6]
      ((st_ff.flag & ~eit_pkg::NMI_MASK) == 32'h0) |-> !irq_o)
      else $error("NMI source raised the maskable interrupt");

   fall_mode_a: assert property ( // [RQ1]
      (fall_hit != 32'h0) |=> ((st_ff.flag & $past(fall_hit)) ==
                               $past(fall_hit)))
      else $error("falling edge in falling mode set no flag");

   both_mode_a: assert property ( // [RQ1]
      (both_hit != 32'h0) |=> ((st_ff.flag & $past(both_hit)) ==
                               $past(both_hit)))
      else $error("edge in both-edge mode set no flag");

   level_off_tick_a: assert property ( // [RQ8]
      (!tick && (lvl_mode & ~st_ff.flag) != 32'h0) |=>
         ((st_ff.flag & $past(lvl_mode & ~st_ff.flag)) == 32'h0))
      else $error("level-mode flag set between sample ticks");

   level_high_a: assert property ( // [RQ9]
      ((lvl_mode & st_ff.filt & ~st_ff.flag) != 32'h0) |=>
         ((st_ff.flag & $past(lvl_mode & st_ff.filt & ~st_ff.flag)) ==
          32'h0))
      else $error("high pin in level mode set its flag");

   group5_write_a: assert property ( // [RQ3]
      (wr_go && avs_byteenable_i[0] &&
       avs_address_i == eit_pkg::IDX_G5_FALL) |=>
         (st_ff.fall[15:8] == ($past(avs_writedata_i[7:0]) & 8'h07)))
      else $error("group-5 falling register not written");

   group6_write_a: assert property ( // [RQ4]
      (wr_go && avs_byteenable_i[0] &&
       avs_address_i == eit_pkg::IDX_G6_FALL) |=>
         (st_ff.fall[23:16] == ($past(avs_writedata_i[7:0]) & 8'hE0)))
      else $error("group-6 falling register not written");

   group_l_write_a: assert property ( // [RQ5]
      (wr_go && avs_byteenable_i[0] &&
       avs_address_i == eit_pkg::IDX_GL_RISE) |=>
         (st_ff.rise[31:24] == ($past(avs_writedata_i[7:0]) & 8'h03)))
      else $error("fourth-group rising register not written");

   group6_read_a: assert property ( // [RQ4]
      (rd_go && avs_address_i == eit_pkg::IDX_G6_RISE) |=>
         (avs_readdata_o == {24'h0, $past(st_ff.rise[23:16])}))
      else $error("group-6 rising register read back wrong");

   byte_lane_a: assert property ( // [RQ14]
      (wr_go && !avs_byteenable_i[0]) |=>
         ($stable(st_ff.fall) && $stable(st_ff.rise)))
      else $error("specification register written with lane 0 off");

   read_stands_a: assert property ( // [RQ14]
      (avs_read_i && !avs_waitrequest_o) |=> $stable(avs_readdata_o))
      else $error("read data changed after the read was taken");

   wait_once_a: assert property ( // [RQ14]
      (bus_req && avs_waitrequest_o) |=> !avs_waitrequest_o)
      else $error("more than one wait cycle inserted");

   soft_clear_a: assert property ( // [RQ13]
      (wr_go && avs_address_i == eit_pkg::IDX_FLAG_CLEAR &&
       avs_byteenable_i == 4'hF) |=>
         ((st_ff.flag & $past(avs_writedata_i & ~flag_set)) == 32'h0))
      else $error("flag survived a software clear");

   ack_clear_a: assert property ( // [RQ10]
      ((irq_ack_i & ~flag_set) != 32'h0) |=>
         ((st_ff.flag & $past(irq_ack_i & ~flag_set)) == 32'h0))
      else $error("acknowledge did not clear the request flag");

   nmi_flag_a: assert property ( // [RQ6]
      ((edge_set & eit_pkg::NMI_MASK) != 32'h0) |=> nmi_o)
      else $error("NMI edge did not raise the NMI output");

   enable_write_a: assert property ( // [RQ16]
      (wr_go && avs_address_i == eit_pkg::IDX_FLAG_ENABLE &&
       avs_byteenable_i == 4'hF) |=>
         (st_ff.enable == ($past(avs_writedata_i) & eit_pkg::VALID_MASK)))
      else $error("enable register not written as masked");

endmodule

// File: verification/eit_pin_model.sv
// Behavioural external sources that drive the interrupt request pins
`timescale 1ns/1ns
module eit_pin_model (
   // Clock
   input wire logic sys_clk_i,
   // Wanted pin levels in flag layout, slow response select
   input wire logic [31:0] lvl_i,
   input wire logic slow_i,
   // Request pins
   output logic nmi_pin_o,
   output logic [5:1] g2_o,
   output logic [2:0] g5_o,
   output logic [7:5] g6_o,
   output logic [1:0] gl_o
);
   logic [31:0] cur_ff = 32'hFFFFFFFF;
   logic [1:0] dly_ff = 2'h0;

   // A slow source takes three clocks to follow a new level
   always @(posedge sys_clk_i) begin
      if (lvl_i !== cur_ff && slow_i && dly_ff != 2'h2) begin
         dly_ff <= dly_ff + 2'h1;
      end else begin
         cur_ff <= lvl_i;
         dly_ff <= 2'h0;
      end
   end

   assign nmi_pin_o = cur_ff[0];
   assign g2_o = cur_ff[5:1];
   assign g5_o = cur_ff[10:8];
   assign g6_o = cur_ff[23:21];
   assign gl_o = cur_ff[25:24];
endmodule

// File: verification/tb.sv
// Self-checking testbench for the trigger-select block
`timescale 1ns/1ns
module tb;
   logic sys_clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic [31:0] adr = 32'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic [3:0] be = 4'hF;
   logic [31:0] ack = 32'h0;
   logic [31:0] lvl = 32'hFFFFFFFF;
   logic slow = 1'b0;
   logic [31:0] rdat;
   logic wreq;
   logic irq;
   logic nmi;
   logic npin;
   logic [5:1] p2;
   logic [2:0] p5;
   logic [7:5] p6;
   logic [1:0] pl;
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [31:0] adr_tab [8] = '{eit_pkg::IDX_G2_FALL, eit_pkg::IDX_G5_FALL,
      eit_pkg::IDX_G6_FALL, eit_pkg::IDX_GL_FALL, eit_pkg::IDX_G2_RISE,
      eit_pkg::IDX_G5_RISE, eit_pkg::IDX_G6_RISE, eit_pkg::IDX_GL_RISE};
   logic [7:0] msk_tab [4] = '{8'h3F, 8'h07, 8'hE0, 8'h03};

   always #4 sys_clk_i = ~sys_clk_i;

   eit_trigger_select uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wdat), .avs_byteenable_i(be),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .nmi_pin_i(npin),
      .group2_request_pin_i(p2), .group5_request_pin_i(p5),
      .group6_request_pin_i(p6), .group_l_request_pin_i(pl),
      .irq_ack_i(ack), .irq_o(irq), .nmi_o(nmi));

   eit_pin_model pins_m (.sys_clk_i(sys_clk_i), .lvl_i(lvl), .slow_i(slow),
      .nmi_pin_o(npin), .g2_o(p2), .g5_o(p5), .g6_o(p6), .gl_o(pl));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task conclude;
      $display("Checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %0t %s got %h want %h", $time, s, got, exp);
      end
   endtask

   // Holds the request until waitrequest is seen low at a rising edge
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d,
            input logic [3:0] b, output logic [31:0] q);
      @(posedge sys_clk_i);
      adr <= a;
      wdat <= d;
      be <= b;
      wr <= w;
      rd <= ~w;
      do @(posedge sys_clk_i); while (wreq !== 1'b0);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask

   task st(output logic [31:0] q);
      bus(1'b0, eit_pkg::IDX_FLAG_STATUS, 32'h0, 4'hF, q);
   endtask

   task pins(input logic [31:0] v, input int n);
      @(posedge sys_clk_i);
      lvl <= v;
      repeat (n) @(posedge sys_clk_i);
   endtask

   task pulse_ack(input logic [31:0] m);
      @(posedge sys_clk_i);
      ack <= m;
      @(posedge sys_clk_i);
      ack <= 32'h0;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_regs;
      logic [31:0] q;
      logic [7:0] m;
      st(q);
      chk(q, 32'h0, "flags after reset");
      for (int i = 0; i < 8; i++) begin
         m = msk_tab[i % 4];
         bus(1'b0, adr_tab[i], 32'h0, 4'hF, q);
         chk(q, (i < 4) ? 32'h0 : {24'h0, m}, "reset value");
         bus(1'b1, adr_tab[i], 32'hFFFFFFFF, 4'hF, q);
         bus(1'b0, adr_tab[i], 32'h0, 4'hF, q);
         chk(q, {24'h0, m}, "byte write");
         bus(1'b1, adr_tab[i], 32'h0, 4'hE, q);
         bus(1'b0, adr_tab[i], 32'h0, 4'hF, q);
         chk(q, {24'h0, m}, "lane 0 off");
         bus(1'b1, adr_tab[i], (i < 4) ? 32'h0 : {24'h0, m}, 4'hF, q);
      end
      bus(1'b1, 32'hFFFFFC50, 32'hFFFFFFFF, 4'hF, q);
      bus(1'b0, 32'hFFFFFC50, 32'h0, 4'hF, q);
      chk(q, 32'h0, "unmapped");
      bus(1'b0, eit_pkg::IDX_FLAG_ENABLE, 32'h0, 4'hF, q);
      chk(q, eit_pkg::ENABLE_RST, "enable reset");
      $display("Register test done");
   endtask

   // Every pin in turn, default rising mode, interrupts all enabled
   task t_walk;
      logic [31:0] q;
      for (int b = 0; b < 32; b++) begin
         if (eit_pkg::VALID_MASK[b]) begin
            slow <= b[0];
            pins(~(32'h1 << b), 16);
            pins(32'hFFFFFFFF, 16);
            st(q);
            chk(q, 32'h1 << b, "pin map");
            chk({30'h0, irq, nmi}, (b == 0) ? 32'h1 : 32'h2, "outs");
            pulse_ack(32'h1 << b);
         end
      end
      $display("Pin walk done");
   endtask

   task t_modes;
      logic [31:0] q;
      logic [1:0] mm;
      for (int m = 0; m < 4; m++) begin
         mm = 2'(m);
         bus(1'b1, eit_pkg::IDX_G5_FALL, 32'(mm[1]) << 1, 4'hF, q);
         bus(1'b1, eit_pkg::IDX_G5_RISE, 32'h5 | (32'(mm[0]) << 1), 4'hF, q);
         bus(1'b1, eit_pkg::IDX_FLAG_CLEAR, 32'hFFFFFFFF, 4'hF, q);
         slow <= mm[0];
         pins(32'hFFFFFDFF, 16);
         st(q);
         chk(q, 32'(4'hD >> mm & 4'h1) << 9, "fall");
         bus(1'b1, eit_pkg::IDX_FLAG_CLEAR, 32'hFFFFFFFF, 4'hF, q);
         pins(32'hFFFFFDFF, 16);
         st(q);
         chk(q, 32'(4'h4 >> mm & 4'h1) << 9, "held low");
         pins(32'hFFFFFFFF, 16);
         st(q);
         chk(q, 32'(4'hE >> mm & 4'h1) << 9, "rise");
         bus(1'b1, eit_pkg::IDX_FLAG_CLEAR, 32'h200, 4'hF, q);
         pins(32'hFFFFFFFF, 16);
         st(q);
         chk(q, 32'h0, "cleared");
      end
      bus(1'b1, eit_pkg::IDX_G5_FALL, 32'h0, 4'hF, q);
      bus(1'b1, eit_pkg::IDX_G5_RISE, 32'h7, 4'hF, q);
      $display("Mode test done");
   endtask

   task t_ack;
      logic [31:0] q;
      bus(1'b1, eit_pkg::IDX_G6_FALL, 32'h40, 4'hF, q);
      bus(1'b1, eit_pkg::IDX_G6_RISE, 32'hA0, 4'hF, q);
      pins(32'hFFBFFFFF, 16);
      chk({31'h0, irq}, 32'h1, "irq up");
      pulse_ack(32'h400000);
      pins(32'hFFBFFFFF, 12);
      st(q);
      chk(q, 32'h400000, "ack refill");
      bus(1'b1, eit_pkg::IDX_FLAG_ENABLE, 32'hFFBFFFFF, 4'hF, q);
      pins(32'hFFBFFFFF, 2);
      chk({31'h0, irq}, 32'h0, "masked");
      bus(1'b1, eit_pkg::IDX_FLAG_ENABLE, 32'hFFFFFFFF, 4'hF, q);
      pins(32'hFFFFFFFF, 16);
      bus(1'b1, eit_pkg::IDX_FLAG_CLEAR, 32'h400000, 4'hF, q);
      pins(32'hFFFFFFFF, 16);
      st(q);
      chk(q, 32'h0, "service end");
      chk({31'h0, irq}, 32'h0, "irq down");
      bus(1'b1, eit_pkg::IDX_G6_FALL, 32'h0, 4'hF, q);
      bus(1'b1, eit_pkg::IDX_G6_RISE, 32'hE0, 4'hF, q);
      $display("Acknowledge test done");
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      logic [31:0] q;
      repeat (4) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      repeat (6) @(posedge sys_clk_i);
      t_regs;
      // Flag enables are all set and stale flags cleared with pins idle, before the pin walk
      bus(1'b1, eit_pkg::IDX_FLAG_ENABLE, 32'hFFFFFFFF, 4'hF, q);
      bus(1'b1, eit_pkg::IDX_FLAG_CLEAR, 32'hFFFFFFFF, 4'hF, q);
      t_walk;
      t_modes;
      t_ack;
      conclude;
   end

   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc > 20000) begin
         num_errors++;
         $display("[ERR] %0t run did not finish in time", $time);
         conclude;
      end
   end
endmodule
